// [adcsq_pkg.sv]
// package: register map, field layout, reset values and timing for the converter control
package adcsq_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // register offsets
    localparam logic [3:0] OFS_CTRL_MAIN  = 4'h0;
    localparam logic [3:0] OFS_CTRL_CLK   = 4'h1;
    localparam logic [3:0] OFS_TEMP_CTRL  = 4'h2;
    localparam logic [3:0] OFS_BGAP_CTRL  = 4'h3;
    localparam logic [3:0] OFS_RES_HIGH   = 4'h4;
    localparam logic [3:0] OFS_RES_LOW    = 4'h5;
    localparam logic [3:0] OFS_CAL_HIGH   = 4'h6;
    localparam logic [3:0] OFS_CAL_LOW    = 4'h7;
    localparam logic [3:0] OFS_IRQ_STAT   = 4'h8;
    localparam logic [3:0] OFS_IRQ_MASK   = 4'h9;
    // field positions
    localparam int BIT_START   = 7;
    localparam int BIT_BUSY    = 6;
    localparam int BIT_PWR_EN  = 5;
    localparam int BIT_ALIGN   = 4;
    localparam int BIT_TEMP_EN = 0;
    localparam int BIT_GAIN    = 1;
    localparam int BIT_BGAP_EN = 0;
    localparam int BIT_IRQ_DONE = 0;
    localparam int LSB_INSEL   = 5;
    localparam int LSB_DIVSEL  = 0;
    // reset values
    localparam logic [7:0] RST_CTRL_MAIN = 8'h00;
    localparam logic [7:0] RST_CTRL_CLK  = 8'h00;
    localparam logic [7:0] RST_TEMP_CTRL = 8'h02;
    localparam logic [7:0] RST_BGAP_CTRL = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK  = 8'h00;
    // input select code of the temperature sensor
    localparam logic [2:0] INSEL_TEMP = 3'h2;
    // conversion timing in converter clocks
    localparam logic [5:0] SAMPLE_CLKS      = 6'h04;
    localparam logic [5:0] SAMPLE_CLKS_TEMP = 6'h2E;
    localparam logic [5:0] CONVERT_CLKS     = 6'h0C;
    // converter power-up delay
    localparam int SYS_CLK_MHZ   = 25;
    localparam int PWRUP_TIME_NS = 1000;
    localparam int PWRUP_CYCLES  = (PWRUP_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
endpackage

// [adcsq_div_if.sv]
// interface: divider select in, converter clock tick out
`timescale 1ns/1ps
interface adcsq_div_if;
    logic [2:0] div_sel;
    logic       run;
    logic       tick;
    modport ctrl (output div_sel, output run, input tick);
    modport div  (input div_sel, input run, output tick);
endinterface

// [adcsq_clkdiv.sv]
// module: power-of-two divider producing one-cycle converter clock ticks
`timescale 1ns/1ps
module adcsq_clkdiv (
    input  wire logic sys_clk,   // system clock
    input  wire logic rstn,      // async reset, active low
    adcsq_div_if.div  dv         // divider select and tick
);
    import adcsq_pkg::*;

    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic       tick_q;
    logic       tick_d;
    logic [6:0] lim;

    always_comb begin
        lim    = 7'((8'h01 << dv.div_sel) - 8'h01);
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (!dv.run) begin
            cnt_d = 7'h00;
        end else if (cnt_q >= lim) begin
            cnt_d  = 7'h00;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 7'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q  <= 7'h00;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign dv.tick = tick_q;

    // with divider code 1 held stable, the divider count steps from 0 to 1 on the next clock
    property p_div_ratio;
        @(posedge sys_clk) disable iff (!rstn)
        (dv.run && cnt_q == 7'h00 && $stable(dv.div_sel) && dv.div_sel == 3'h1)
            |=> (cnt_q == 7'h01);
    endproperty
    a_div_ratio: assert property (p_div_ratio)
        else $error("divider count did not advance");
endmodule

// [adcsq_top.sv]
// module: converter sequencer with clock divider, references and registers
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module adcsq_top #(
    parameter logic [11:0] CAL85_VALUE = 12'h800  // factory calibration value
) (
    input  wire logic               sys_clk,       // system clock, 25 MHz
    input  wire logic               rstn,          // async reset, active low
    input  wire logic [3:0]         reg_addr,      // register address
    input  wire logic [7:0]         reg_wdata,     // write data
    input  wire logic               reg_wr,        // write strobe
    input  wire logic               reg_rd,        // read strobe
    output logic [7:0]              reg_rdata,     // read data, cycle after
    output logic                    irq,           // interrupt level
    output logic                    conv_pwr_on,   // converter powered
    output logic                    bgap_on,       // bandgap circuit on
    output logic                    bgap_out_oe,   // bandgap output driven
    output logic                    temp_on,       // temperature sensor on
    output logic [2:0]              input_sel,     // converter input select
    output logic [3:0]              chan_sel,      // external channel select
    output logic [1:0]              vref_sel,      // reference select
    output logic                    sample_hold,   // sampling phase active
    input  wire logic [11:0]        conv_value     // digitised analog value
);
    import adcsq_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONV   = 3'b100
    } adcsq_state_type;

    // ===============================================================
    // registers
    adcsq_state_type st_q, st_d;
    logic [7:0]  main_q, main_d;
    logic [7:0]  clk_q, clk_d;
    logic [7:0]  temp_q, temp_d;
    logic [7:0]  bgap_q, bgap_d;
    logic [7:0]  mask_q, mask_d;
    logic [7:0]  stat_q, stat_d;
    logic [11:0] res_q, res_d;
    logic [5:0]  cnt_q, cnt_d;
    logic        busy_q, busy_d;
    logic        armed_q, armed_d;
    logic [7:0]  rdata_q, rdata_d;
    logic        irq_q;
    logic [15:0] pwr_cnt_q, pwr_cnt_d;
    logic        done;
    logic        start_req;
    logic        pwr_ready;
    logic [7:0]  res_hi, res_lo;
    logic        temp_conv;

    adcsq_div_if div_bus ();

    adcsq_clkdiv u_div (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .dv      (div_bus.div)
    );

    assign div_bus.div_sel = clk_q[LSB_DIVSEL +: 3];
    assign div_bus.run     = (st_q != ST_IDLE);

    // ===============================================================
    // result formatting
    always_comb begin
        if (main_q[BIT_ALIGN]) begin
            res_hi = {4'h0, res_q[11:8]};
            res_lo = res_q[7:0];
        end else begin
            res_hi = res_q[11:4];
            res_lo = {res_q[3:0], 4'h0};
        end
    end

    assign temp_conv = (clk_q[LSB_INSEL +: 3] == INSEL_TEMP);
    assign pwr_ready = (pwr_cnt_q >= 16'(PWRUP_CYCLES));

    // ===============================================================
    // register writes and start detection
    always_comb begin
        main_d  = main_q;
        clk_d   = clk_q;
        temp_d  = temp_q;
        bgap_d  = bgap_q;
        mask_d  = mask_q;
        armed_d = armed_q;
        start_req = 1'b0;
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_CTRL_MAIN: begin
                    main_d = {reg_wdata[7], 1'b0, reg_wdata[5:0]};
                    if (reg_wdata[BIT_START]) begin
                        armed_d = 1'b1;
                    end else if (armed_q) begin
                        armed_d   = 1'b0;
                        start_req = 1'b1;
                    end
                end
                OFS_CTRL_CLK: begin
                    clk_d = reg_wdata;
                    if (reg_wdata[LSB_INSEL +: 3] == 3'h7) begin
                        clk_d[LSB_INSEL +: 3] = clk_q[LSB_INSEL +: 3];
                    end
                end
                OFS_TEMP_CTRL: temp_d = {6'h00, reg_wdata[1:0]};
                OFS_BGAP_CTRL: bgap_d = {7'h00, reg_wdata[0]};
                OFS_IRQ_MASK:  mask_d = {7'h00, reg_wdata[0]};
                default: ;
            endcase
        end
    end

    // ===============================================================
    // conversion sequencer
    always_comb begin
        st_d      = st_q;
        cnt_d     = cnt_q;
        busy_d    = busy_q;
        res_d     = res_q;
        done      = 1'b0;
        pwr_cnt_d = pwr_cnt_q;
        if (!main_q[BIT_PWR_EN]) begin
            pwr_cnt_d = 16'h0000;
        end else if (!pwr_ready) begin
            pwr_cnt_d = pwr_cnt_q + 16'h0001;
        end
        unique case (st_q)
            ST_IDLE: begin
                // start honoured only when powered and idle
                if (start_req && main_q[BIT_PWR_EN] && pwr_ready) begin
                    st_d   = ST_SAMPLE;
                    busy_d = 1'b1;
                    cnt_d  = temp_conv ? SAMPLE_CLKS_TEMP : SAMPLE_CLKS;
                end
            end
            ST_SAMPLE: begin
                if (div_bus.tick) begin
                    if (cnt_q == 6'h01) begin
                        st_d  = ST_CONV;
                        cnt_d = CONVERT_CLKS;
                    end else begin
                        cnt_d = cnt_q - 6'h01;
                    end
                end
            end
            ST_CONV: begin
                if (div_bus.tick) begin
                    if (cnt_q == 6'h01) begin
                        st_d   = ST_IDLE;
                        busy_d = 1'b0;
                        res_d  = conv_value;
                        done   = 1'b1;
                    end else begin
                        cnt_d = cnt_q - 6'h01;
                    end
                end
            end
            default: begin
                st_d   = ST_IDLE;
                busy_d = 1'b0;
            end
        endcase
        if (!main_q[BIT_PWR_EN] && st_q != ST_IDLE) begin
            st_d   = ST_IDLE;
            busy_d = 1'b0;
        end
    end

    // ===============================================================
    // interrupt status and read data
    always_comb begin
        stat_d = stat_q;
        if (reg_rd && reg_addr == OFS_IRQ_STAT) begin
            stat_d = 8'h00;
        end
        if (done) begin
            stat_d[BIT_IRQ_DONE] = 1'b1;
        end
        rdata_d = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_CTRL_MAIN: rdata_d = {main_q[7], busy_q, main_q[5:0]};
                OFS_CTRL_CLK:  rdata_d = clk_q;
                OFS_TEMP_CTRL: rdata_d = temp_q;
                OFS_BGAP_CTRL: rdata_d = bgap_q;
                OFS_RES_HIGH:  rdata_d = res_hi;
                OFS_RES_LOW:   rdata_d = res_lo;
                OFS_CAL_HIGH:  rdata_d = CAL85_VALUE[11:4];
                OFS_CAL_LOW:   rdata_d = {CAL85_VALUE[3:0], 4'h0};
                OFS_IRQ_STAT:  rdata_d = stat_q;
                OFS_IRQ_MASK:  rdata_d = mask_q;
                default:       rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_q      <= ST_IDLE;
            main_q    <= RST_CTRL_MAIN;
            clk_q     <= RST_CTRL_CLK;
            temp_q    <= RST_TEMP_CTRL;
            bgap_q    <= RST_BGAP_CTRL;
            mask_q    <= RST_IRQ_MASK;
            stat_q    <= 8'h00;
            res_q     <= 12'h000;
            cnt_q     <= 6'h00;
            busy_q    <= 1'b0;
            armed_q   <= 1'b0;
            rdata_q   <= 8'h00;
            irq_q     <= 1'b0;
            pwr_cnt_q <= 16'h0000;
        end else begin
            st_q      <= st_d;
            main_q    <= main_d;
            clk_q     <= clk_d;
            temp_q    <= temp_d;
            bgap_q    <= bgap_d;
            mask_q    <= mask_d;
            stat_q    <= stat_d;
            res_q     <= res_d;
            cnt_q     <= cnt_d;
            busy_q    <= busy_d;
            armed_q   <= armed_d;
            rdata_q   <= rdata_d;
            irq_q     <= |(stat_d & mask_d);
            pwr_cnt_q <= pwr_cnt_d;
        end
    end

    // ===============================================================
    // outputs, all from flip-flops
    assign reg_rdata   = rdata_q;
    assign irq         = irq_q;
    assign conv_pwr_on = main_q[BIT_PWR_EN];
    assign bgap_on     = bgap_q[BIT_BGAP_EN];
    assign bgap_out_oe = bgap_q[BIT_BGAP_EN];
    assign temp_on     = temp_q[BIT_TEMP_EN];
    assign input_sel   = clk_q[LSB_INSEL +: 3];
    assign chan_sel    = main_q[3:0];
    assign vref_sel    = clk_q[4:3];
    assign sample_hold = st_q[1];

    // ===============================================================
    // checks
    sequence s_start_wr;
        reg_wr && reg_addr == OFS_CTRL_MAIN && !reg_wdata[BIT_START] && armed_q;
    endsequence

    property p_busy_on_start;
        @(posedge sys_clk) disable iff (!rstn)
        (s_start_wr and (st_q == ST_IDLE && main_q[BIT_PWR_EN] && pwr_ready))
            |=> busy_q && st_q == ST_SAMPLE;
    endproperty
    a_busy_on_start: assert property (p_busy_on_start)
        else $error("start sequence did not set busy");

    property p_ignore_busy;
        @(posedge sys_clk) disable iff (!rstn)
        (busy_q && st_q == ST_CONV && cnt_q > 6'h01 && main_q[BIT_PWR_EN])
            |=> busy_q;
    endproperty
    a_ignore_busy: assert property (p_ignore_busy)
        else $error("busy dropped during conversion");

    property p_no_start_off;
        @(posedge sys_clk) disable iff (!rstn)
        (st_q == ST_IDLE && !main_q[BIT_PWR_EN]) |=> !busy_q;
    endproperty
    a_no_start_off: assert property (p_no_start_off)
        else $error("conversion began while disabled");

    property p_done_flag;
        @(posedge sys_clk) disable iff (!rstn)
        $fell(busy_q) && main_q[BIT_PWR_EN] |-> stat_q[BIT_IRQ_DONE];
    endproperty
    a_done_flag: assert property (p_done_flag)
        else $error("completion flag not set");

    property p_irq_mask;
        @(posedge sys_clk) disable iff (!rstn)
        irq == |(stat_q & mask_q);
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt level differs from enabled flags");

    property p_result_update;
        @(posedge sys_clk) disable iff (!rstn)
        (st_q == ST_CONV && div_bus.tick && cnt_q == 6'h01 && main_q[BIT_PWR_EN])
            |=> res_q == $past(conv_value) && !busy_q;
    endproperty
    a_result_update: assert property (p_result_update)
        else $error("result not stored as busy clears");

    property p_sample_len;
        @(posedge sys_clk) disable iff (!rstn)
        ($rose(busy_q) && !temp_conv) |-> cnt_q == SAMPLE_CLKS;
    endproperty
    a_sample_len: assert property (p_sample_len)
        else $error("sampling length wrong");

    property p_reserved_zero;
        @(posedge sys_clk) disable iff (!rstn)
        bgap_q[7:1] == 7'h00 && temp_q[7:2] == 6'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("unimplemented bits set");

    property p_bgap_hiz;
        @(posedge sys_clk) disable iff (!rstn)
        !bgap_q[BIT_BGAP_EN] |-> !bgap_out_oe;
    endproperty
    a_bgap_hiz: assert property (p_bgap_hiz)
        else $error("bandgap driven while disabled");

    property p_cal_low;
        @(posedge sys_clk) disable iff (!rstn)
        (reg_rd && reg_addr == OFS_CAL_LOW) |=> reg_rdata[3:0] == 4'h0;
    endproperty
    a_cal_low: assert property (p_cal_low)
        else $error("calibration low nibble not zero");
endmodule

// [tb_top.sv]
// testbench: register-level checks of the converter control block
`timescale 1ns/1ps
module tb_top;
    import adcsq_pkg::*;
    localparam logic [11:0] CAL = 12'hA5C;  // arbitrary calibration value
    localparam int SENSOR_SETTLE_CYCLES = 10;  // sensor settle time in clocks
    logic        sys_clk;
    logic        rstn;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        irq;
    logic        conv_pwr_on;
    logic        bgap_on;
    logic        bgap_out_oe;
    logic        temp_on;
    logic [2:0]  input_sel;
    logic [3:0]  chan_sel;
    logic [1:0]  vref_sel;
    logic        sample_hold;
    logic [11:0] conv_value;
    logic [7:0]  rd_val;
    int          n_mismatch;
    int          num_checks;

    adcsq_top #(.CAL85_VALUE(CAL)) adcsq_top_i (
        .sys_clk     (sys_clk),
        .rstn        (rstn),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .reg_wr      (reg_wr),
        .reg_rd      (reg_rd),
        .reg_rdata   (reg_rdata),
        .irq         (irq),
        .conv_pwr_on (conv_pwr_on),
        .bgap_on     (bgap_on),
        .bgap_out_oe (bgap_out_oe),
        .temp_on     (temp_on),
        .input_sel   (input_sel),
        .chan_sel    (chan_sel),
        .vref_sel    (vref_sel),
        .sample_hold (sample_hold),
        .conv_value  (conv_value)
    );

    // ==========================================
    // clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // ==========================================
    // compare and bus tasks
    task automatic report_and_stop();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check8(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check1(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rd_chk(input string nm, input logic [3:0] a,
                          input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        check8(nm, e, d);
    endtask

    // ==========================================
    // one conversion: divider code, input, align, mask, value, clocks
    task automatic convert(input logic [2:0] dv, input logic [2:0] ins,
                           input logic al, input logic m,
                           input logic [11:0] v, input int n);
        int         cnt;
        int         r;
        int         lim;
        logic       in_time;
        logic [7:0] d;
        logic [7:0] eh;
        logic [7:0] el;
        r   = 1 << dv;
        lim = m ? 5000 : n * r + 2 * r + 4;
        eh  = al ? {4'h0, v[11:8]} : v[11:4];
        el  = al ? v[7:0] : {v[3:0], 4'h0};
        @(posedge sys_clk);
        conv_value <= v;
        wr(OFS_IRQ_MASK, {7'h00, m});
        wr(OFS_CTRL_CLK, {ins, 2'b01, dv});
        check8("input_sel", {5'h00, ins}, {5'h00, input_sel});
        check8("vref_sel", 8'h01, {6'h00, vref_sel});
        wr(OFS_CTRL_MAIN, {3'b101, al, 4'h0});
        check1("conv_pwr_on", 1'b1, conv_pwr_on);
        repeat (PWRUP_CYCLES) @(posedge sys_clk);
        wr(OFS_CTRL_MAIN, {3'b001, al, 4'h0});
        rd(OFS_CTRL_MAIN, d);
        check1("busy set", 1'b1, d[BIT_BUSY]);
        check1("sample_hold", 1'b1, sample_hold);
        // a second start while busy must leave this conversion alone
        wr(OFS_CTRL_MAIN, {3'b101, al, 4'h0});
        wr(OFS_CTRL_MAIN, {3'b001, al, 4'h0});
        cnt = 6;
        while (cnt < lim && !(m && irq === 1'b1)) begin
            @(posedge sys_clk);
            #1;
            cnt++;
            if (!m) check1("irq masked", 1'b0, irq);
        end
        if (m && cnt >= lim) begin
            n_mismatch++;
            report_and_stop();
        end
        in_time = (cnt >= n * r) && (cnt <= n * r + 2 * r + 3);
        if (m) check1("duration", 1'b1, in_time);
        rd(OFS_CTRL_MAIN, d);
        check1("busy clear", 1'b0, d[BIT_BUSY]);
        check1("sample_hold off", 1'b0, sample_hold);
        rd_chk("result high", OFS_RES_HIGH, eh);
        rd_chk("result low", OFS_RES_LOW, el);
        rd_chk("status set", OFS_IRQ_STAT, 8'h01);
        rd_chk("status cleared", OFS_IRQ_STAT, 8'h00);
        @(posedge sys_clk);
        #1;
        check1("irq after clear", 1'b0, irq);
    endtask

    // ==========================================
    // main sequence
    initial begin
        rstn       = 1'b0;
        reg_addr   = 4'h0;
        reg_wdata  = 8'h00;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        conv_value = 12'h000;
        n_mismatch = 0;
        num_checks = 0;
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        // reset values and read-only calibration pair
        rd_chk("main", OFS_CTRL_MAIN, RST_CTRL_MAIN);
        rd_chk("clk", OFS_CTRL_CLK, 8'h00);
        rd_chk("temp ctrl", OFS_TEMP_CTRL, 8'h02);
        rd_chk("bgap ctrl", OFS_BGAP_CTRL, 8'h00);
        rd_chk("mask", OFS_IRQ_MASK, 8'h00);
        rd_chk("status", OFS_IRQ_STAT, 8'h00);
        rd_chk("cal high", OFS_CAL_HIGH, CAL[11:4]);
        rd_chk("cal low", OFS_CAL_LOW, {CAL[3:0], 4'h0});
        wr(OFS_CAL_HIGH, 8'h00);
        wr(OFS_CAL_LOW, 8'hFF);
        rd_chk("cal high ro", OFS_CAL_HIGH, CAL[11:4]);
        rd_chk("cal low ro", OFS_CAL_LOW, {CAL[3:0], 4'h0});
        check1("oe at reset", 1'b0, bgap_out_oe);
        check1("temp_on at reset", 1'b0, temp_on);
        check1("irq at reset", 1'b0, irq);
        wr(4'hA, 8'hFF);
        rd_chk("unmapped", 4'hA, 8'h00);
        // bandgap enable and output drive
        wr(OFS_BGAP_CTRL, 8'hFF);
        rd_chk("bgap ctrl", OFS_BGAP_CTRL, 8'h01);
        check1("bgap_on", 1'b1, bgap_on);
        check1("oe on", 1'b1, bgap_out_oe);
        wr(OFS_BGAP_CTRL, 8'hFE);
        check1("oe off", 1'b0, bgap_out_oe);
        check1("bgap_on off", 1'b0, bgap_on);
        // sensor control
        wr(OFS_TEMP_CTRL, 8'hFF);
        rd_chk("temp ctrl", OFS_TEMP_CTRL, 8'h03);
        check1("temp_on", 1'b1, temp_on);
        wr(OFS_TEMP_CTRL, 8'h02);
        check1("temp_on off", 1'b0, temp_on);
        // fields of the control registers
        wr(OFS_CTRL_CLK, 8'h5A);
        wr(OFS_CTRL_CLK, 8'hE2);
        check8("input_sel kept", 8'h02, {5'h00, input_sel});
        wr(OFS_CTRL_MAIN, 8'h0B);
        check8("chan_sel", 8'h0B, {4'h0, chan_sel});
        // start sequence while disabled
        wr(OFS_CTRL_MAIN, 8'h80);
        wr(OFS_CTRL_MAIN, 8'h00);
        repeat (40) @(posedge sys_clk);
        rd_chk("main idle", OFS_CTRL_MAIN, 8'h00);
        rd_chk("status idle", OFS_IRQ_STAT, 8'h00);
        // start inside the power-up delay is ignored
        wr(OFS_CTRL_MAIN, 8'hA0);
        wr(OFS_CTRL_MAIN, 8'h20);
        rd_chk("early start", OFS_CTRL_MAIN, 8'h20);
        // every divider code, both alignments
        for (int k = 0; k < 8; k++) begin
            convert(k[2:0], 3'h0, k[0], 1'b1, {k[2:0], 9'h0A5}, 16);
        end
        // sensor powered and settled, converter clock of 1.28 us
        wr(OFS_TEMP_CTRL, 8'h03);
        repeat (SENSOR_SETTLE_CYCLES) @(posedge sys_clk);
        convert(3'h5, INSEL_TEMP, 1'b1, 1'b1, 12'h3E7, 58);
        // bandgap enabled before it is selected, clock of 640 ns
        wr(OFS_BGAP_CTRL, 8'h01);
        convert(3'h4, 3'h1, 1'b0, 1'b0, 12'hC3D, 16);
        // results held and start ignored while disabled
        wr(OFS_CTRL_MAIN, 8'h00);
        check1("conv_pwr_on off", 1'b0, conv_pwr_on);
        @(posedge sys_clk);
        conv_value <= 12'hFFF;
        wr(OFS_CTRL_MAIN, 8'h80);
        wr(OFS_CTRL_MAIN, 8'h00);
        repeat (40) @(posedge sys_clk);
        rd_chk("result kept", OFS_RES_HIGH, 8'hC3);
        rd_chk("no event", OFS_IRQ_STAT, 8'h00);
        report_and_stop();
    end
endmodule
